/* src/poll_wait_defs.vh */
// Constants of the polled-wait unit: bus offsets, fields, resets and timing.
// Included by every design file except the pin synchroniser; definitions only.
`ifndef POLL_WAIT_DEFS_VH
`define POLL_WAIT_DEFS_VH

// Register byte addresses
`define ADDR_CTRL        8'h00
`define ADDR_PIN_CFG     8'h04
`define ADDR_PIN_LEVEL   8'h08
`define ADDR_CMD         8'h0C
`define ADDR_STATUS      8'h10
`define ADDR_IRQ_STAT    8'h14
`define ADDR_IRQ_MASK    8'h18
`define ADDR_SCRATCH     8'h80
`define SCRATCH_FIRST    8'h80
`define SCRATCH_LAST     8'h9C

// Control register fields
`define CTRL_MODE_LSB    0
`define CTRL_MODE_MSB    2
`define CTRL_SLOT_LSB    4
`define CTRL_SLOT_MSB    6
`define MODE_RESET       3'h0
`define SLOT_RESET       3'h0

// Poll modes
`define MODE_OFF_SAVED   3'h1
`define MODE_ACTIVE      3'h2
`define MODE_RUN_SAVED   3'h3
`define MODE_RUN_ACTIVE  3'h4

// Command register fields
`define CMD_DUR_LSB      0
`define CMD_DUR_MSB      3
`define DUR_NO_NAP       4'h8

// Interrupt bits
`define IRQ_MATCH        0
`define IRQ_SWITCH       1
`define IRQ_IGNORED      2

// Timing
`define CLK_HZ           100000000
`define NAP_BASE_MS      18
`define NAP_BASE_CYC     (`CLK_HZ / 1000 * `NAP_BASE_MS)
`define WAKE_HOLD_MS     18
`define WAKE_HOLD_CYC    (`CLK_HZ / 1000 * `WAKE_HOLD_MS)

`endif

/* src/pin_sync.v */
// Three-stage synchroniser with agreement filter for the polled pins.
// Assumes asynchronous pins and one system clock.
`timescale 1ns/1ps
module pin_sync
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Pins
  input  wire [7:0]  pin_i,
  output reg  [7:0]  pin_o
);

  reg [7:0] s1_q;
  reg [7:0] s2_q;
  reg [7:0] s3_q;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q  <= 8'h00;
      s2_q  <= 8'h00;
      s3_q  <= 8'h00;
      pin_o <= 8'h00;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once the last two stages agree
      pin_o <= (s2_q & s3_q) | (pin_o & (s2_q | s3_q));
    end
  end

endmodule

/* src/nap_timer.v */
// Free-running base tick for low-power naps, plus a tick counter.
// Assumes the sequencer restarts the count at each nap entry.
`timescale 1ns/1ps
`include "poll_wait_defs.vh"
module nap_timer
#(
  parameter BASE_CYC = `NAP_BASE_CYC
)
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Control
  input  wire        start_i,
  input  wire [2:0]  exp_i,
  output reg         done_o
);

  reg [31:0] base_q;
  reg [7:0]  ticks_q;
  wire       tick;
  wire [7:0] goal;

  // Free-running so the nap length is only tick accurate, like a real wake timer
  assign tick = (base_q == BASE_CYC - 1);
  assign goal = 8'h01 << exp_i;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      base_q  <= 32'h0;
      ticks_q <= 8'h00;
      done_o  <= 1'b0;
    end
    else
    begin
      base_q <= tick ? 32'h0 : base_q + 32'h1;
      done_o <= 1'b0;
      if (start_i)
        ticks_q <= 8'h00;
      else if (tick)
      begin
        if (ticks_q + 8'h01 == goal)
        begin
          ticks_q <= 8'h00;
          done_o  <= 1'b1;
        end
        else
          ticks_q <= ticks_q + 8'h01;
      end
    end
  end

endmodule

/* src/polled_wait_wakeup.v */
// Polled-wait unit: halts the sequencer until a polled pin matches.
// Assumes a classic Wishbone master and asynchronous pins.
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "poll_wait_defs.vh"
module polled_wait_wakeup
#(
  parameter NAP_CYC  = `NAP_BASE_CYC,
  parameter HOLD_CYC = `WAKE_HOLD_CYC
)
(
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Sequencer
  input  wire        instr_done_i,
  output reg         exec_halt_o,
  output reg         resume_o,
  output reg         slot_switch_o,
  output reg  [2:0]  slot_o,
  // Pins
  input  wire [7:0]  pin_i,
  output reg         low_power_o,
  output reg         force_input_o,
  // Interrupt
  output reg         irq_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_NAP  = 3'h1;
  localparam ST_WAKE = 3'h2;
  localparam ST_RUN  = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg  [2:0]  mode_q;
  reg  [2:0]  slot_q;
  reg  [7:0]  cfg_q;
  reg  [7:0]  level_q;
  reg  [3:0]  dur_q;
  reg  [2:0]  st_q;
  reg  [31:0] hold_q;
  reg  [2:0]  irq_stat_q;
  reg  [2:0]  irq_mask_q;
  reg  [7:0]  scratch_q [0:7];
  reg         nap_start_q;
  wire [7:0]  pins;
  wire        nap_done;
  wire [7:0]  hits;
  wire        match;
  wire        wr;
  wire        rd;
  wire        cmd_wr;
  wire        accept;
  wire        run_armed;
  wire        fire;
  wire        poll_now;
  reg  [2:0]  ev;
  integer     i;

  // Modes that let the wait start
  function mode_waits;
    input [2:0] m;
    begin
      mode_waits = (m == `MODE_ACTIVE) || (m == `MODE_RUN_ACTIVE);
    end
  endfunction

  // Modes that arm a polled-run switch
  function mode_runs;
    input [2:0] m;
    begin
      mode_runs = (m == `MODE_RUN_SAVED) || (m == `MODE_RUN_ACTIVE);
    end
  endfunction

  // Scratch word for a bus address, or 4'h8 outside the window
  function [3:0] scratch_word;
    input [7:0] a;
    begin
      if (a >= `SCRATCH_FIRST && a <= `SCRATCH_LAST && a[1:0] == 2'b00)
        scratch_word = {1'b0, a[4:2]};
      else
        scratch_word = 4'h8;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  pin_sync u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .pin_i (pin_i),
    .pin_o (pins)
  );

  nap_timer #(.BASE_CYC(NAP_CYC)) u_nap
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (nap_start_q),
    .exp_i   (dur_q[2:0]),
    .done_o  (nap_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Match logic

  assign hits      = cfg_q & ~(pins ^ level_q);
  assign match     = |hits;
  assign wr        = cyc_i & stb_i & we_i & ~ack_o;
  assign rd        = cyc_i & stb_i & ~we_i & ~ack_o;
  assign cmd_wr    = wr & (adr_i == `ADDR_CMD) & sel_i[0];
  // Codes above 8 are refused like a wait in the wrong mode
  assign accept    = mode_waits(mode_q) && (cfg_q != 8'h00) && (dat_i[3:0] <= `DUR_NO_NAP);
  assign run_armed = mode_runs(mode_q);
  // Poll between instructions, at each nap end, or every cycle in the no-nap wait
  assign poll_now  = (st_q == ST_IDLE && instr_done_i)
                   || (st_q == ST_NAP && nap_done)
                   || (st_q == ST_RUN);
  assign fire      = poll_now & match & run_armed;

  ////////////////////////////////////////////////////////////////////////////
  // Wait sequencer

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q          <= ST_IDLE;
      dur_q         <= 4'h0;
      hold_q        <= 32'h0;
      nap_start_q   <= 1'b0;
      exec_halt_o   <= 1'b0;
      resume_o      <= 1'b0;
      slot_switch_o <= 1'b0;
      low_power_o   <= 1'b0;
      force_input_o <= 1'b0;
    end
    else
    begin
      nap_start_q   <= 1'b0;
      resume_o      <= 1'b0;
      slot_switch_o <= fire;
      case (st_q)
        ST_IDLE:
        begin
          if (cmd_wr && accept)
          begin
            dur_q       <= dat_i[3:0];
            exec_halt_o <= 1'b1;
            if (dat_i[3:0] == `DUR_NO_NAP)
              st_q <= ST_RUN;
            else
            begin
              st_q        <= ST_NAP;
              nap_start_q <= 1'b1;
              low_power_o <= 1'b1;
            end
          end
          else if (cmd_wr)
            resume_o <= 1'b1;
        end
        ST_NAP:
        begin
          // Back to low power one cycle after the wake sample, so each repeat shows a wake
          if (nap_start_q)
            low_power_o <= 1'b1;
          if (nap_done)
          begin
            low_power_o   <= 1'b0;
            force_input_o <= 1'b1;
            hold_q        <= 32'h0;
            if (match)
            begin
              st_q <= ST_WAKE;
            end
            else
            begin
              st_q        <= ST_NAP;
              nap_start_q <= 1'b1;
            end
          end
        end
        ST_WAKE:
        begin
          // Pins float as inputs for the whole wake reset
          if (hold_q == HOLD_CYC - 1)
          begin
            force_input_o <= 1'b0;
            exec_halt_o   <= 1'b0;
            resume_o      <= 1'b1;
            st_q          <= ST_IDLE;
          end
          else
            hold_q <= hold_q + 32'h1;
        end
        ST_RUN:
        begin
          // Pins come through the synchroniser, so response trails the pin by a few cycles
          if (match)
          begin
            exec_halt_o <= 1'b0;
            resume_o    <= 1'b1;
            st_q        <= ST_IDLE;
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events

  always @*
  begin
    ev = 3'h0;
    ev[`IRQ_MATCH]   = poll_now & match;
    ev[`IRQ_SWITCH]  = fire;
    ev[`IRQ_IGNORED] = cmd_wr & ~accept & (st_q == ST_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, status and scratchpad

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q     <= `MODE_RESET;
      slot_q     <= `SLOT_RESET;
      cfg_q      <= 8'h00;
      level_q    <= 8'h00;
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq_o      <= 1'b0;
      slot_o     <= 3'h0;
      for (i = 0; i < 8; i = i + 1)
        scratch_q[i] <= 8'h00;
    end
    else
    begin
      // Level interrupt trails the status bits by one cycle
      irq_o  <= |(irq_stat_q & irq_mask_q);
      slot_o <= slot_q;
      if (wr && sel_i[0])
      begin
        case (adr_i)
          `ADDR_CTRL:
          begin
            mode_q <= dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            slot_q <= dat_i[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB];
          end
          `ADDR_PIN_CFG:   cfg_q      <= dat_i[7:0];
          `ADDR_PIN_LEVEL: level_q    <= dat_i[7:0];
          `ADDR_IRQ_MASK:  irq_mask_q <= dat_i[2:0];
          default:         mode_q     <= mode_q;
        endcase
      end
      if (fire)
      begin
        if (mode_q == `MODE_RUN_SAVED)
          mode_q <= `MODE_OFF_SAVED;
        else
          mode_q <= `MODE_ACTIVE;
      end
      // Latched per-pin hits; software clears them by writing ones
      for (i = 0; i < 8; i = i + 1)
      begin
        if (poll_now && hits[i])
          scratch_q[i] <= 8'h01;
        else if (wr && sel_i[0] && scratch_word(adr_i) == i[3:0] && dat_i[0])
          scratch_q[i] <= 8'h00;
      end
      // Set wins over the clear by read
      if (rd && adr_i == `ADDR_IRQ_STAT)
        irq_stat_q <= ev;
      else
        irq_stat_q <= irq_stat_q | ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus response

  // Read data is registered with the acknowledge and is zero otherwise
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end
    else
    begin
      ack_o <= (wr | rd);
      dat_o <= 32'h0;
      if (rd)
      begin
        case (adr_i)
          `ADDR_CTRL:      dat_o <= {25'h0, slot_q, 1'b0, mode_q};
          `ADDR_PIN_CFG:   dat_o <= {24'h0, cfg_q};
          `ADDR_PIN_LEVEL: dat_o <= {24'h0, level_q};
          `ADDR_CMD:       dat_o <= {28'h0, dur_q};
          `ADDR_STATUS:    dat_o <= {21'h0, pins, st_q};
          `ADDR_IRQ_STAT:  dat_o <= {29'h0, irq_stat_q};
          `ADDR_IRQ_MASK:  dat_o <= {29'h0, irq_mask_q};
          default:
          begin
            if (scratch_word(adr_i) != 4'h8)
              dat_o <= {24'h0, scratch_q[adr_i[4:2]]};
          end
        endcase
      end
    end
  end

endmodule

/* sim/pin_driver.sv */
// Far-side model: external sources on the polled input pins.
// Assumes the bench names the wanted levels; one system clock.
`timescale 1ns/1ps
module pin_driver
(
  // Clock
  input  wire       clk_i,
  // Wanted and driven levels
  input  wire [7:0] want_i,
  output reg  [7:0] pin_o
);
  // A change lands a cycle late, never in the same step as the bench
  initial pin_o = 8'hFF;
  always @(posedge clk_i)
    pin_o <= want_i;
endmodule

/* sim/polled_wait_wakeup_monitor.sv */
// Port checker for the polled-wait unit.
// Assumes the bind below and one clock domain.
`timescale 1ns/1ps
module polled_wait_wakeup_monitor
#(
  parameter NAP_CYC  = 20,
  parameter HOLD_CYC = 5
)
(
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  // Sequencer and pins
  input wire        exec_halt_o,
  input wire        resume_o,
  input wire        slot_switch_o,
  input wire        low_power_o,
  input wire        force_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  ack_answer_a: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o) else $error("no ack");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  rdata_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data not idle");
  nap_halts_a: assert property (low_power_o |-> exec_halt_o) else $error("nap without halt");
  resume_nap_a: assert property (resume_o |-> !low_power_o) else $error("resume in nap");
  halt_ends_a: assert property (resume_o |=> !exec_halt_o) else $error("halt stays");
  wake_source_a: assert property ($rose(force_input_o) |-> $past(low_power_o)) else $error("wake w/o nap");
  wake_hold_a: assert property ($rose(force_input_o) |-> force_input_o[*5]) else $error("wake short");
  switch_pulse_a: assert property (slot_switch_o |=> !slot_switch_o) else $error("switch long");
endmodule
bind polled_wait_wakeup polled_wait_wakeup_monitor #(.NAP_CYC(NAP_CYC), .HOLD_CYC(HOLD_CYC))
  polled_wait_wakeup_monitor_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .dat_o(dat_o), .ack_o(ack_o), .exec_halt_o(exec_halt_o), .resume_o(resume_o),
  .slot_switch_o(slot_switch_o), .low_power_o(low_power_o), .force_input_o(force_input_o));

/* sim/tb.sv */
// Bench for the polled-wait unit: bus tasks and scripted waits.
// Assumes short nap and hold counts of 20 and 5 cycles.
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, instr_done_i;
  logic [7:0]  adr_i, want_q;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, rd;
  wire  [31:0] dat_o;
  wire  [7:0]  pin_w;
  wire  [2:0]  slot_o;
  wire         ack_o, exec_halt_o, resume_o, slot_switch_o, low_power_o, force_input_o, irq_o;
  wire  [3:0]  ev = {~low_power_o, low_power_o, slot_switch_o, resume_o};
  int          n_fail, check_count, cyc_cnt, n;
  ////////////////////////////////////////////////////////////
  pin_driver pin_driver_i (.clk_i(clk_i), .want_i(want_q), .pin_o(pin_w));
  polled_wait_wakeup #(.NAP_CYC(20), .HOLD_CYC(5)) polled_wait_wakeup_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .instr_done_i(instr_done_i), .exec_halt_o(exec_halt_o),
    .resume_o(resume_o), .slot_switch_o(slot_switch_o), .slot_o(slot_o), .pin_i(pin_w),
    .low_power_o(low_power_o), .force_input_o(force_input_o), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Polls each edge; a one-cycle pulse is seen at exactly one edge
  task automatic wt(input int s, input int lim);
    n = 0;
    while (ev[s] !== 1'b1 && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(n < lim, 1);
  endtask
  task end_sim;
    $display("TB: checks=%0d errors=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    cyc_cnt = 0;
    forever
    begin
      @(posedge clk_i);
      cyc_cnt++;
      if (cyc_cnt == 20000)
      begin
        n_fail++;
        end_sim;
      end
    end
  end
  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, instr_done_i} = 'h0;
    rst_i = 1'b1;
    sel_i = 4'hF;
    want_q = 8'hFF;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 8'h0C, 32'h8);
    wt(0, 5);
    wb(1'b1, 8'h04, 32'h1);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h00, 32'h2);
    wb(1'b1, 8'h0C, 32'h8);
    repeat (30) @(posedge clk_i);
    chk({exec_halt_o, low_power_o}, 2'b10);
    want_q <= 8'hFE;
    wt(0, 12);
    @(posedge clk_i);
    chk(exec_halt_o, 0);
    chk(irq_o, 0);
    wb(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 1);
    rdc(8'h14, 32'h5);
    rdc(8'h14, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq_o, 0);
    want_q <= 8'hFF;
    rdc(8'h80, 32'h1);
    wb(1'b1, 8'h80, 32'h1);
    rdc(8'h80, 32'h0);
    rdc(8'h40, 32'h0);
    // Every nap first misses, then the pin matches during the repeat
    for (int d = 0; d < 3; d++)
    begin
      want_q <= 8'hFF;
      wb(1'b1, 8'h0C, d);
      wt(2, 10);
      wt(3, 200);
      chk(n > (1 << d) * 20 - 20 && n <= (1 << d) * 20 + 2, 1);
      wt(2, 10);
      chk({force_input_o, exec_halt_o}, 2'b11);
      want_q <= 8'hFE;
      wt(0, (2 << d) * 20 + 20);
    end
    want_q <= 8'hFF;
    repeat (8) @(posedge clk_i);
    wb(1'b1, 8'h00, 32'h54);
    wb(1'b1, 8'h0C, 32'h8);
    want_q <= 8'hFE;
    wt(1, 15);
    chk(slot_o, 3'h5);
    rdc(8'h00, 32'h52);
    wb(1'b1, 8'h00, 32'h33);
    instr_done_i <= 1'b1;
    @(posedge clk_i);
    instr_done_i <= 1'b0;
    wt(1, 8);
    rdc(8'h00, 32'h31);
    end_sim;
  end
endmodule
